// *** design/asrc_host.sv ***
// host controller driving a 512k x 8 asynchronous static ram
`default_nettype none
`include "asrc_defines.svh"
module asrc_host #(
    parameter int unsigned WAKE_CYC = (`ASRC_TREC_PD_MS * `ASRC_NS_PER_MS) / `ASRC_CLK_NS
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [1:0] grade,
    input wire logic req_valid,
    input wire asrc_pkg::asrc_req_t req,
    output logic req_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_rdata,
    input wire logic sleep_req,
    output logic sleep_ack,
    output asrc_pkg::asrc_pins_t pins,
    input wire logic [7:0] dq_i,
    output logic [7:0] dq_o,
    output logic dq_oe_n
);
    localparam logic [`ASRC_CNT_W-1:0] ACC_F = `ASRC_CNT_W'(`ASRC_CYC(`ASRC_TACC_FAST_NS));
    localparam logic [`ASRC_CNT_W-1:0] ACC_M = `ASRC_CNT_W'(`ASRC_CYC(`ASRC_TACC_MID_NS));
    localparam logic [`ASRC_CNT_W-1:0] ACC_S = `ASRC_CNT_W'(`ASRC_CYC(`ASRC_TACC_SLOW_NS));
    localparam logic [`ASRC_CNT_W-1:0] WSU_F = `ASRC_CNT_W'(`ASRC_CYC(`ASRC_TWSU_FAST_NS));
    localparam logic [`ASRC_CNT_W-1:0] WSU_M = `ASRC_CNT_W'(`ASRC_CYC(`ASRC_TWSU_MID_NS));
    localparam logic [`ASRC_CNT_W-1:0] WSU_S = `ASRC_CNT_W'(`ASRC_CYC(`ASRC_TWSU_SLOW_NS));
    localparam logic [`ASRC_CNT_W-1:0] TURN_C = `ASRC_CNT_W'(`ASRC_CYC(`ASRC_TDIS_SLOW_NS));
    localparam logic [`ASRC_CNT_W-1:0] WAKE_C = `ASRC_CNT_W'(WAKE_CYC);

    // unknown grade codes fall back to the slowest timing, which is safe for all
    function automatic logic [`ASRC_CNT_W-1:0] pick(input logic [1:0] g, input logic [`ASRC_CNT_W-1:0] f,
        input logic [`ASRC_CNT_W-1:0] m, input logic [`ASRC_CNT_W-1:0] s);
        if (g == `ASRC_GRADE_FAST) begin
            return f;
        end else if (g == `ASRC_GRADE_MID) begin
            return m;
        end
        return s;
    endfunction

    // one clock off a phase budget
    function automatic logic [`ASRC_CNT_W-1:0] cnt_dec(input logic [`ASRC_CNT_W-1:0] c);
        return c - `ASRC_CNT_W'(1);
    endfunction

    asrc_pkg::asrc_state_t state_q;
    logic [`ASRC_CNT_W-1:0] cnt_q;
    logic [7:0] dq_s1_q;
    logic [7:0] dq_s2_q;
    logic [1:0] grade_q;
    logic cnt_done;
    logic take;
    logic go_sleep;
    logic acc_done;
    logic rd_done;

    // a power-down request wins over a pending access
    assign go_sleep = (state_q == asrc_pkg::ASRC_IDLE) && sleep_req;
    assign take = (state_q == asrc_pkg::ASRC_IDLE) && !sleep_req && req_valid && req_ready;
    assign cnt_done = (cnt_q <= `ASRC_CNT_W'(1));
    assign acc_done = ((state_q == asrc_pkg::ASRC_RD) || (state_q == asrc_pkg::ASRC_WR)) && cnt_done;
    assign rd_done = (state_q == asrc_pkg::ASRC_RD) && cnt_done;

    // read data passes two flops before use
    always_ff @(posedge core_clk) begin
        dq_s1_q <= dq_i;
        dq_s2_q <= dq_s1_q;
    end

    // grade latched only while idle so a phase never changes length midway
    always_ff @(posedge core_clk) begin
        if (rst) begin
            grade_q <= `ASRC_GRADE_SLOW;
        end else if (state_q == asrc_pkg::ASRC_IDLE) begin
            grade_q <= grade;
        end
    end

    // sequencer: each phase but idle and sleep lasts a counted number of clocks, set by the latched grade for read and write
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= asrc_pkg::ASRC_IDLE;
            cnt_q <= '0;
        end else begin
            unique case (state_q)
                asrc_pkg::ASRC_IDLE: begin
                    if (go_sleep) begin
                        state_q <= asrc_pkg::ASRC_SLEEP;
                    end else if (take && req.write) begin
                        cnt_q <= pick(grade_q, WSU_F, WSU_M, WSU_S);
                        state_q <= asrc_pkg::ASRC_WR;
                    end else if (take) begin
                        // extra cycles cover the input synchroniser
                        cnt_q <= pick(grade_q, ACC_F, ACC_M, ACC_S) + `ASRC_CNT_W'(`ASRC_SYNC_CYC);
                        state_q <= asrc_pkg::ASRC_RD;
                    end
                end
                asrc_pkg::ASRC_RD: begin
                    if (cnt_done) begin
                        cnt_q <= TURN_C;
                        state_q <= asrc_pkg::ASRC_TURN;
                    end else begin
                        cnt_q <= cnt_dec(cnt_q);
                    end
                end
                asrc_pkg::ASRC_WR: begin
                    if (cnt_done) begin
                        cnt_q <= `ASRC_CNT_W'(`ASRC_DHOLD_CYC);
                        state_q <= asrc_pkg::ASRC_TURN;
                    end else begin
                        cnt_q <= cnt_dec(cnt_q);
                    end
                end
                asrc_pkg::ASRC_TURN: begin
                    if (cnt_done) begin
                        state_q <= asrc_pkg::ASRC_IDLE;
                    end else begin
                        cnt_q <= cnt_dec(cnt_q);
                    end
                end
                asrc_pkg::ASRC_SLEEP: begin
                    if (!sleep_req) begin
                        cnt_q <= WAKE_C;
                        state_q <= asrc_pkg::ASRC_WAKE;
                    end
                end
                asrc_pkg::ASRC_WAKE: begin
                    if (cnt_done) begin
                        state_q <= asrc_pkg::ASRC_IDLE;
                    end else begin
                        cnt_q <= cnt_dec(cnt_q);
                    end
                end
                default: begin
                    state_q <= asrc_pkg::ASRC_IDLE;
                end
            endcase
        end
    end

    // memory pins change only at phase boundaries
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pins.addr <= '0;
            pins.sel_n <= 1'b1;
            pins.wr_n <= 1'b1;
            pins.oe_n <= 1'b1;
        end else if (go_sleep) begin
            pins.sel_n <= 1'b1;
        end else if (take) begin
            pins.addr <= req.addr;
            pins.sel_n <= 1'b0;
            // on a write the strobe falls with select so the memory never drives
            pins.wr_n <= !req.write;
            pins.oe_n <= req.write;
        end else if (acc_done) begin
            // strobe, gate and select rise together; address still held
            pins.wr_n <= 1'b1;
            pins.oe_n <= 1'b1;
            pins.sel_n <= 1'b1;
        end
    end

    // write data stays on the bus one clock past the strobe's rising edge
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dq_o <= '0;
            dq_oe_n <= 1'b1;
        end else if (take) begin
            if (req.write) begin
                dq_o <= req.wdata;
            end
            // a read leaves the bus to the memory
            dq_oe_n <= !req.write;
        end else if (state_q == asrc_pkg::ASRC_TURN) begin
            dq_oe_n <= 1'b1;
        end
    end

    // one access at a time; refused while busy, asleep or waking
    always_ff @(posedge core_clk) begin
        if (rst) begin
            req_ready <= 1'b0;
        end else begin
            req_ready <= (state_q == asrc_pkg::ASRC_IDLE) && !sleep_req && !take;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            rsp_valid <= rd_done;
            if (rd_done) begin
                rsp_rdata <= dq_s2_q;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sleep_ack <= 1'b0;
        end else if (go_sleep) begin
            sleep_ack <= 1'b1;
        end else if ((state_q == asrc_pkg::ASRC_SLEEP) && !sleep_req) begin
            sleep_ack <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** design/asrc_defines.svh ***
// timing and geometry constants for the async sram host controller
`ifndef ASRC_DEFINES_SVH
`define ASRC_DEFINES_SVH
`define ASRC_ADDR_W 19
`define ASRC_DATA_W 8
`define ASRC_CLK_NS 100
// grade codes
`define ASRC_GRADE_FAST 2'h0
`define ASRC_GRADE_MID 2'h1
`define ASRC_GRADE_SLOW 2'h2
// least times in ns per grade; power-down recovery in ms
`define ASRC_TACC_FAST_NS 55
`define ASRC_TACC_MID_NS 70
`define ASRC_TACC_SLOW_NS 100
`define ASRC_TWSU_FAST_NS 50
`define ASRC_TWSU_MID_NS 60
`define ASRC_TWSU_SLOW_NS 80
`define ASRC_TDIS_SLOW_NS 35
`define ASRC_TREC_PD_MS 5
`define ASRC_NS_PER_MS 1000000
// cycle counts, least times rounded up, at least one cycle
`define ASRC_CYC(ns) ((((ns) + `ASRC_CLK_NS - 1) / `ASRC_CLK_NS) < 1 ? 1 : \
    (((ns) + `ASRC_CLK_NS - 1) / `ASRC_CLK_NS))
`define ASRC_CNT_W 16
// input synchroniser depth and write data hold, in clocks
`define ASRC_SYNC_CYC 2
`define ASRC_DHOLD_CYC 1
`endif

// *** design/asrc_pkg.sv ***
// types for the async sram host controller
`default_nettype none
package asrc_pkg;
    typedef struct packed {
        logic [18:0] addr;
        logic [7:0] wdata;
        logic write;
    } asrc_req_t;
    typedef struct packed {
        logic [18:0] addr;
        logic sel_n;
        logic wr_n;
        logic oe_n;
    } asrc_pins_t;
    typedef enum logic [2:0] {
        ASRC_IDLE, ASRC_RD, ASRC_WR, ASRC_TURN, ASRC_SLEEP, ASRC_WAKE
    } asrc_state_t;
endpackage
`default_nettype wire

// *** tb/asrc_checker.sv ***
// protocol checker for the sram host controller pins
`default_nettype none
module asrc_checker #(
    parameter int unsigned WAKE_CYC = 4
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic rsp_valid,
    input wire logic sleep_ack,
    input wire asrc_pkg::asrc_pins_t pins,
    input wire logic dq_oe_n
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_addr_hold: assert property (!pins.wr_n |=> $stable(pins.addr)) else $error("addr moved");
    a_no_fight: assert property (!pins.sel_n && !pins.oe_n |-> dq_oe_n) else $error("bus fight");
    a_rsp_free: assert property (rsp_valid |-> dq_oe_n && pins.wr_n) else $error("drive at rsp");
    a_wr_sel: assert property ($rose(pins.wr_n) |-> $past(!pins.sel_n)) else $error("no sel");
    a_sleep_desel: assert property (sleep_ack |-> pins.sel_n) else $error("sel in sleep");
    a_wake_quiet: assert property ($fell(sleep_ack) && WAKE_CYC >= 4 |-> pins.sel_n[*4]) else $error("wake");
    a_read_len: assert property ($fell(pins.oe_n) |-> ##[2:5] rsp_valid) else $error("read late");
    c_read: cover property (rsp_valid);
    c_write: cover property ($rose(pins.wr_n));
    c_sleep: cover property ($fell(sleep_ack));
endmodule
bind asrc_host asrc_checker #(.WAKE_CYC(WAKE_CYC)) i_asrc_checker (.core_clk, .rst, .rsp_valid, .sleep_ack,
    .pins, .dq_oe_n);
`default_nettype wire

// *** tb/asrc_sram_model.sv ***
// behavioural 512k x 8 async static ram
`default_nettype none
module asrc_sram_model (
    input wire asrc_pkg::asrc_pins_t pins,
    input wire logic [7:0] dq_o,
    input wire logic dq_oe_n,
    output logic [7:0] dq_i
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [bit [18:0]];
    logic [7:0] last = 8'h00;
    wire logic wr_on = !pins.sel_n && !pins.wr_n;
    wire logic rd_on = !pins.sel_n && pins.wr_n && !pins.oe_n;
    wire logic rd_late;
    wire logic [18:0] addr_late;
    assign #10 rd_late = rd_on;
    assign #10 addr_late = pins.addr;
    always @(negedge wr_on) mem[pins.addr] = dq_o;
    always @(posedge dq_oe_n) last = dq_o;
    always @* begin
        if (!dq_oe_n)
            dq_i = dq_o;
        else if (rd_on && rd_late)
            dq_i = mem.exists(addr_late) ? mem[addr_late] : 8'h3C;
        else
            dq_i = ~last;
    end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the sram host controller
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin err_total++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] grade = 2'h0;
    logic req_valid = 1'b0;
    asrc_pkg::asrc_req_t req = '0;
    logic sleep_req = 1'b0;
    logic req_ready, rsp_valid, sleep_ack, dq_oe_n;
    logic [7:0] rsp_rdata, dq_i, dq_o;
    asrc_pkg::asrc_pins_t pins;
    int err_total = 0;
    int checks = 0;
    always #50 core_clk = ~core_clk;
    asrc_host #(.WAKE_CYC(4)) i_asrc_host (.core_clk, .rst, .grade, .req_valid, .req, .req_ready, .rsp_valid,
        .rsp_rdata, .sleep_req, .sleep_ack, .pins, .dq_i, .dq_o, .dq_oe_n);
    asrc_sram_model i_asrc_sram_model (.pins, .dq_o, .dq_oe_n, .dq_i);
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic access(input logic w, input logic [18:0] a, input logic [7:0] d);
        int n;
        @(negedge core_clk);
        req_valid = 1'b1;
        req = '{addr: a, wdata: d, write: w};
        // ready is looked at between edges, never in the edge's own time step
        for (n = 0; n < 50 && req_ready !== 1'b1; n++) @(negedge core_clk);
        `CHK("taken", 1'b1, req_ready)
        @(negedge core_clk);
        req_valid = 1'b0;
        `CHK("busy", 1'b0, req_ready)
        for (n = 0; n < 10 && rsp_valid !== 1'b1 && !w; n++) @(negedge core_clk);
        if (!w) begin
            `CHK("rsp_valid", 1'b1, rsp_valid)
            `CHK("rdata", d, rsp_rdata)
        end
    endtask
    task automatic t_edges;
        access(1'b1, 19'h00000, 8'h11);
        access(1'b1, 19'h00000, 8'hA5);
        access(1'b1, 19'h7FFFF, 8'h5A);
        access(1'b0, 19'h00000, 8'hA5);
        access(1'b0, 19'h7FFFF, 8'h5A);
    endtask
    task automatic t_grades;
        for (int g = 0; g < 4; g++) begin
            @(negedge core_clk);
            grade = g[1:0];
            access(1'b1, 19'h00100 + 19'(g), 8'hC0 + 8'(g));
            access(1'b0, 19'h00100 + 19'(g), 8'hC0 + 8'(g));
        end
    endtask
    task automatic t_sleep;
        @(negedge core_clk);
        sleep_req = 1'b1;
        req_valid = 1'b1;
        repeat (3) @(negedge core_clk);
        `CHK("sleep_ack", 1'b1, sleep_ack)
        `CHK("ready", 1'b0, req_ready)
        `CHK("sel_n", 1'b1, pins.sel_n)
        sleep_req = 1'b0;
        req_valid = 1'b0;
        repeat (3) @(negedge core_clk);
        `CHK("wake_sel", 1'b1, pins.sel_n)
        `CHK("wake_ready", 1'b0, req_ready)
        `CHK("wake_ack", 1'b0, sleep_ack)
        access(1'b0, 19'h7FFFF, 8'h5A);
    endtask
    initial begin
        repeat (4) @(negedge core_clk);
        `CHK("rst_sel", 1'b1, pins.sel_n)
        `CHK("rst_oe", 1'b1, dq_oe_n)
        rst = 1'b0;
        t_edges();
        t_grades();
        t_sleep();
        tally_and_finish();
    end
    // far beyond the hundred or so cycles the tests need
    initial begin
        #100000;
        err_total++;
        tally_and_finish();
    end
endmodule
`undef CHK
`default_nettype wire
